//--- design/pbb_bridge.sv
`timescale 1ns/10ps
// Notes on behaviour
// - peripheral data moves over byte bus
// - word write stores upper byte only
// - word read returns register in upper byte
// - unmapped writes are dropped
// - unmapped reads return undefined value
// - bit ops read, modify, write byte
// - timer address reads counter, writes reload
// - port read gives pins for inputs
// - rmw copies input pin levels into latch
// - ram decoded from base, variant length
// - rom decoded from zero to end
// - direction register reads all ones
module pbb_bridge #(
  parameter logic [15:0] ROM_END   = pbb_pkg::ROM_END_DEF,
  parameter logic [15:0] RAM_BYTES = pbb_pkg::RAM_BYTES_DEF,
  parameter int          PWIDTH    = 8
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // cpu access
  input  wire logic              req,
  input  wire logic              req_we,
  input  wire logic              req_word,
  input  wire logic [15:0]       req_addr,
  input  wire logic [15:0]       req_wdata,
  output logic                   ack,
  output logic      [15:0]       rdata,
  // cpu bit operation
  input  wire logic              bit_req,
  input  wire logic [2:0]        bit_op,
  input  wire logic [2:0]        bit_num,
  input  wire logic              bit_carry,
  input  wire logic [15:0]       bit_addr,
  output logic                   bit_done,
  // memory selects
  output logic                   rom_sel,
  output logic                   ram_sel,
  output logic                   unmapped,
  // timer
  input  wire logic [7:0]        timer_count,
  output logic      [7:0]        timer_reload,
  output logic                   timer_reload_wr,
  // port pins
  input  wire logic [PWIDTH-1:0] pin_in,
  output logic      [PWIDTH-1:0] pin_out,
  output logic      [PWIDTH-1:0] pin_oe_n
);
  typedef struct packed {
    pbb_pkg::pbb_state_t state;
    logic [15:0]         addr;
    logic [2:0]          op;
    logic [2:0]          num;
    logic                carry;
    logic [7:0]          data;
    logic                ack;
    logic [15:0]         rdata;
    logic                done;
    logic [7:0]          reload;
    logic                reload_wr;
  } pbb_st_t;
  pbb_st_t st;
  pbb_st_t next_st;

  logic              io_we;
  logic [15:0]       io_addr;
  logic [7:0]        io_wdata;
  logic [PWIDTH-1:0] port_rd;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  // rom window
  function automatic logic is_rom(input logic [15:0] a);
    is_rom = (a >= pbb_pkg::ROM_BASE) && (a <= ROM_END);
  endfunction
  function automatic logic is_ram(input logic [15:0] a);
    logic [16:0] top;
    top    = {1'b0, pbb_pkg::RAM_BASE} + {1'b0, RAM_BYTES};
    is_ram = (a >= pbb_pkg::RAM_BASE) && ({1'b0, a} < top);
  endfunction
  function automatic logic is_io(input logic [15:0] a);
    is_io = (a == pbb_pkg::TMR_ADDR) || (a == pbb_pkg::PDATA_ADDR) || (a == pbb_pkg::PDIR_ADDR);
  endfunction
  function automatic logic [7:0] io_read(input logic [15:0] a, input logic [7:0] cnt,
                                         input logic [7:0] prt);
    case (a)
      pbb_pkg::TMR_ADDR:   io_read = cnt;
      pbb_pkg::PDATA_ADDR: io_read = prt;
      pbb_pkg::PDIR_ADDR:  io_read = pbb_pkg::BYTE_ONES;
      default:             io_read = pbb_pkg::UNDEF_BYTE;
    endcase
  endfunction
  function automatic logic [7:0] modify(input logic [7:0] d, input logic [2:0] op,
                                        input logic [2:0] n, input logic c);
    logic [7:0] r;
    r = d;
    case (op)
      pbb_pkg::BIT_SET_OP:               r[n] = 1'b1;
      pbb_pkg::BIT_CLEAR_OP:             r[n] = 1'b0;
      pbb_pkg::BIT_INVERT_OP:            r[n] = ~d[n];
      pbb_pkg::CARRY_TO_BIT_OP:          r[n] = c;
      pbb_pkg::INVERTED_CARRY_TO_BIT_OP: r[n] = ~c;
      default:                           r = d;
    endcase
    modify = r;
  endfunction

  assign rom_sel  = is_rom(req_addr);
  assign ram_sel  = is_ram(req_addr);
  assign unmapped = ~rom_sel & ~ram_sel & ~is_io(req_addr) & (req_addr < pbb_pkg::IO_BASE);

  // ----------------------------------------------------------------
  // byte bus write path
  // ----------------------------------------------------------------
  always_comb begin
    io_we    = 1'b0;
    io_addr  = req_addr;
    io_wdata = pbb_pkg::BYTE_ZERO;
    if (st.state == pbb_pkg::ST_WRITE) begin
      io_we    = 1'b1;
      io_addr  = st.addr;
      io_wdata = st.data;
    end else if (st.state == pbb_pkg::ST_IDLE && req && req_we && !bit_req) begin
      // a bit op in the same cycle wins, so the plain write must not land unacknowledged
      // only mapped io stores
      io_we    = is_io(req_addr);
      io_wdata = req_word ? req_wdata[15:8] : req_wdata[7:0];
    end
  end

  pbb_port #(
    .WIDTH (PWIDTH)
  ) u_port (
    .clk      (clk),
    .rst      (rst),
    .wr_data  (io_we && io_addr == pbb_pkg::PDATA_ADDR),
    .wr_dir   (io_we && io_addr == pbb_pkg::PDIR_ADDR),
    .wdata    (io_wdata[PWIDTH-1:0]),
    .pin_in   (pin_in),
    .pin_out  (pin_out),
    .pin_oe_n (pin_oe_n),
    .rd_data  (port_rd)
  );

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_st           = st;
    next_st.ack       = 1'b0;
    next_st.done      = 1'b0;
    next_st.reload_wr = 1'b0;
    if (io_we && io_addr == pbb_pkg::TMR_ADDR) begin
      next_st.reload    = io_wdata;
      next_st.reload_wr = 1'b1;
    end
    case (st.state)
      pbb_pkg::ST_IDLE: begin
        // bit operations win over plain requests in the same cycle
        if (bit_req) begin
          next_st.state = pbb_pkg::ST_MODIFY;
          next_st.addr  = bit_addr;
          next_st.op    = bit_op;
          next_st.num   = bit_num;
          next_st.carry = bit_carry;
          next_st.data  = io_read(bit_addr, timer_count, port_rd);
        end else if (req) begin
          next_st.ack = 1'b1;
          if (!req_we) begin
            next_st.rdata = req_word ? {io_read(req_addr, timer_count, port_rd), pbb_pkg::UNDEF_BYTE}
                                     : {pbb_pkg::BYTE_ZERO, io_read(req_addr, timer_count, port_rd)};
          end
        end
      end
      pbb_pkg::ST_MODIFY: begin
        next_st.data  = modify(st.data, st.op, st.num, st.carry);
        next_st.state = pbb_pkg::ST_WRITE;
      end
      pbb_pkg::ST_WRITE: begin
        next_st.done  = 1'b1;
        next_st.state = pbb_pkg::ST_IDLE;
      end
      default: next_st.state = pbb_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st        <= '0;
      st.state  <= pbb_pkg::ST_IDLE;
      st.reload <= pbb_pkg::RELOAD_RST;
    end else begin
      st <= next_st;
    end
  end

  assign ack             = st.ack;
  assign rdata           = st.rdata;
  assign bit_done        = st.done;
  assign timer_reload    = st.reload;
  assign timer_reload_wr = st.reload_wr;
endmodule

//--- design/pbb_pkg.sv
package pbb_pkg;
  // ----------------------------------------------------------------
  // address map
  // ----------------------------------------------------------------
  localparam logic [15:0] ROM_BASE       = 16'h0000;
  localparam logic [15:0] ROM_END_DEF    = 16'h9fff;
  localparam logic [15:0] RAM_BASE       = 16'hfb80;
  localparam logic [15:0] RAM_BYTES_DEF  = 16'h0800;
  localparam logic [15:0] IO_BASE        = 16'hff80;
  localparam logic [15:0] TMR_ADDR       = 16'hffb3;
  localparam logic [15:0] PDATA_ADDR     = 16'hffd6;
  localparam logic [15:0] PDIR_ADDR      = 16'hffe6;
  // ----------------------------------------------------------------
  // data constants
  // ----------------------------------------------------------------
  localparam logic [7:0]  BYTE_ZERO      = 8'h00;
  localparam logic [7:0]  BYTE_ONES      = 8'hff;
  localparam logic [7:0]  RELOAD_RST     = 8'h00;
  localparam logic [7:0]  UNDEF_BYTE     = 8'h00;
  // ----------------------------------------------------------------
  // bit operations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    BIT_SET_OP               = 3'h0,
    BIT_CLEAR_OP             = 3'h1,
    BIT_INVERT_OP            = 3'h2,
    CARRY_TO_BIT_OP          = 3'h3,
    INVERTED_CARRY_TO_BIT_OP = 3'h4
  } pbb_bitop_t;
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_MODIFY = 3'b010,
    ST_WRITE  = 3'b100
  } pbb_state_t;
endpackage

//--- design/pbb_port.sv
`timescale 1ns/10ps
module pbb_port #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // byte bus writes
  input  wire logic             wr_data,
  input  wire logic             wr_dir,
  input  wire logic [WIDTH-1:0] wdata,
  // pins
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_out,
  output logic      [WIDTH-1:0] pin_oe_n,
  // read view
  output logic      [WIDTH-1:0] rd_data
);
  typedef struct packed {
    logic [WIDTH-1:0] sync1;
    logic [WIDTH-1:0] sync2;
    logic [WIDTH-1:0] sync3;
    logic [WIDTH-1:0] level;
    logic [WIDTH-1:0] port3_output_latch;
    logic [WIDTH-1:0] port3_direction_control;
  } pbb_port_st_t;
  pbb_port_st_t st;
  pbb_port_st_t next_st;

  always_comb begin
    next_st       = st;
    next_st.sync1 = pin_in;
    next_st.sync2 = st.sync1;
    next_st.sync3 = st.sync2;
    // a level counts once two stages agree; filters single-cycle glitches
    for (int i = 0; i < WIDTH; i++) begin
      if (st.sync2[i] == st.sync3[i]) begin
        next_st.level[i] = st.sync3[i];
      end
    end
    if (wr_data) begin
      next_st.port3_output_latch = wdata;
    end
    if (wr_dir) begin
      next_st.port3_direction_control = wdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pin_out  = st.port3_output_latch;
  assign pin_oe_n = ~st.port3_direction_control;
  assign rd_data  = (st.port3_direction_control & st.port3_output_latch)
                  | (~st.port3_direction_control & st.level);
endmodule

//--- verification/pbb_bridge_sva.sv
`timescale 1ns/10ps
module pbb_bridge_sva #(
  parameter logic [15:0] ROM_END   = pbb_pkg::ROM_END_DEF,
  parameter logic [15:0] RAM_BYTES = pbb_pkg::RAM_BYTES_DEF
) (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // cpu access
  input wire logic        req,
  input wire logic        req_we,
  input wire logic        req_word,
  input wire logic [15:0] req_addr,
  input wire logic [15:0] req_wdata,
  input wire logic        ack,
  input wire logic [15:0] rdata,
  input wire logic        bit_req,
  input wire logic        bit_done,
  // decode and timer
  input wire logic        rom_sel,
  input wire logic        ram_sel,
  input wire logic        unmapped,
  input wire logic [7:0]  timer_count,
  input wire logic [7:0]  timer_reload,
  input wire logic        timer_reload_wr
);
  logic [1:0] busy;
  logic       bit_take;
  logic       take;
  logic [7:0] wbyte;
  // a bit op blanks plain requests for two cycles, so track it here
  assign bit_take = bit_req && busy == 2'h0;
  assign take     = req && !bit_req && busy == 2'h0;
  assign wbyte    = req_word ? req_wdata[15:8] : req_wdata[7:0];
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy <= 2'h0;
    end else begin
      busy <= (busy != 2'h0) ? busy - 2'h1 : (bit_req ? 2'h2 : 2'h0);
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_ack_take:
    assert property (take |=> ack) else $error("ack missing after request");
  chk_ack_cause:
    assert property (ack |-> $past(take)) else $error("ack without request");
  chk_bit_seq:
    assert property (bit_take |=> (!bit_done) [*2] ##1 bit_done) else $error("bit op length wrong");
  chk_done_cause:
    assert property (bit_done |-> $past(bit_take, 3)) else $error("bit done without bit op");
  chk_reload_load:
    assert property (take && req_we && req_addr == pbb_pkg::TMR_ADDR |=> timer_reload_wr && timer_reload == $past(wbyte))
      else $error("reload byte wrong");
  chk_reload_cause:
    assert property (timer_reload_wr |-> $past(take && req_we && req_addr == pbb_pkg::TMR_ADDR) || $past(bit_take, 3))
      else $error("reload written without cause");
  chk_unmapped_drop:
    assert property (take && req_we && unmapped |=> !timer_reload_wr && $stable(timer_reload))
      else $error("unmapped write stored");
  chk_counter_read:
    assert property (take && !req_we && req_addr == pbb_pkg::TMR_ADDR |=> rdata == ($past(req_word)
      ? {$past(timer_count), 8'h00} : {8'h00, $past(timer_count)})) else $error("counter read wrong");
  chk_dir_ones:
    assert property (take && !req_we && !req_word && req_addr == pbb_pkg::PDIR_ADDR |=> rdata == 16'h00ff)
      else $error("direction read not ones");
  chk_rom_decode:
    assert property (rom_sel == (req_addr <= ROM_END)) else $error("rom decode wrong");
  chk_ram_decode:
    assert property (ram_sel == (req_addr >= pbb_pkg::RAM_BASE && req_addr - pbb_pkg::RAM_BASE < RAM_BYTES))
      else $error("ram decode wrong");
  cover property (bit_take);
  cover property (take && req_we && unmapped);
  cover property (ack && req_word);
endmodule

//--- verification/pbb_bridge_test.sv
`timescale 1ns/10ps
module pbb_bridge_test;
  localparam logic [15:0] TA = pbb_pkg::TMR_ADDR;
  localparam logic [15:0] DA = pbb_pkg::PDATA_ADDR;
  localparam logic [15:0] IA = pbb_pkg::PDIR_ADDR;
  logic        clk, rst, req, req_we, req_word, bit_req, bit_carry, c;
  logic        ack, bit_done, rom_sel, ram_sel, unmapped, timer_reload_wr;
  logic [15:0] req_addr, req_wdata, rdata, bit_addr;
  logic [2:0]  bit_op, bit_num, b;
  logic [7:0]  timer_count, timer_reload, pin_in, pin_out, pin_oe_n, ext, tc, x;
  logic [16:0] expq[$];
  logic [16:0] e;
  logic [15:0] at[7] = '{16'h0000, 16'h7fff, 16'h8000, 16'hfb7f, 16'hfb80, 16'hff7f, 16'hff80};
  logic [2:0]  dt[7] = '{3'h4, 3'h4, 3'h1, 3'h1, 3'h2, 3'h2, 3'h0};
  int          errors, checked, n;
  pbb_bridge #(.ROM_END(16'h7fff), .RAM_BYTES(16'h0400)) dut (
    .clk(clk), .rst(rst), .req(req), .req_we(req_we), .req_word(req_word), .req_addr(req_addr),
    .req_wdata(req_wdata), .ack(ack), .rdata(rdata), .bit_req(bit_req), .bit_op(bit_op), .bit_num(bit_num),
    .bit_carry(bit_carry), .bit_addr(bit_addr), .bit_done(bit_done), .rom_sel(rom_sel), .ram_sel(ram_sel),
    .unmapped(unmapped), .timer_count(timer_count), .timer_reload(timer_reload),
    .timer_reload_wr(timer_reload_wr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n));
  pbb_pin_model pins (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext(ext), .pin_in(pin_in));
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // bounded wait on ack or bit done, checked just after each edge
  task automatic wait_hi(input logic sel);
    for (n = 0; n < 20 && (sel ? bit_done : ack) !== 1'b1; n++) begin
      @(posedge clk);
      #5;
    end
    if (n == 20) begin
      errors++;
      wrap_up();
    end
  endtask
  // req drops once ack shows, else an idle bridge would take it again
  task automatic acc(input logic we, wd, input logic [15:0] a, d, input logic [16:0] ex);
    @(posedge clk);
    #5;
    expq.push_back(ex);
    req = 1'b1;
    req_we = we;
    req_word = wd;
    req_addr = a;
    req_wdata = d;
    wait_hi(1'b0);
    req = 1'b0;
  endtask
  task automatic bop(input logic [2:0] op, num, input logic cy, input logic [15:0] a);
    @(posedge clk);
    #5;
    bit_req = 1'b1;
    bit_op = op;
    bit_num = num;
    bit_carry = cy;
    bit_addr = a;
    @(posedge clk);
    #5;
    bit_req = 1'b0;
    wait_hi(1'b1);
  endtask
  always @(posedge clk) begin
    if (ack === 1'b1) begin
      cmp("ack count", 16'h0001, {15'h0000, expq.size() > 0});
      e = expq.pop_front();
      if (e[16]) cmp("rdata", e[15:0], rdata);
    end
  end
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    {rst, req, req_we, req_word, bit_req, bit_carry} = 6'h21;
    {req_addr, req_wdata, bit_addr, bit_op, bit_num, timer_count} = '0;
    ext = 8'h40;
    errors = 0;
    checked = 0;
    void'($urandom(32'h919d));
    repeat (16) @(posedge clk);
    #5;
    rst = 1'b0;
    cmp("oe_n", 16'h00ff, {8'h00, pin_oe_n});
    cmp("latch", 16'h0000, {8'h00, pin_out});
    cmp("reload", 16'h0000, {8'h00, timer_reload});
    for (int i = 0; i < 7; i++) begin
      req_addr = at[i];
      @(posedge clk);
      #5;
      cmp("decode", {13'h0000, dt[i]}, {13'h0000, rom_sel, ram_sel, unmapped});
    end
    $display("test reset and decode done");
    acc(1'b1, 1'b0, TA, 16'h00a5, 17'h0_0000);
    cmp("reload", 16'h00a5, {8'h00, timer_reload});
    acc(1'b1, 1'b1, TA, 16'h3c96, 17'h0_0000);
    cmp("reload word", 16'h003c, {8'h00, timer_reload});
    tc = 8'($urandom);
    timer_count = tc;
    acc(1'b0, 1'b0, TA, 16'h0000, {9'h100, tc});
    acc(1'b0, 1'b1, TA, 16'h0000, {1'b1, tc, 8'h00});
    acc(1'b1, 1'b0, 16'h8000, 16'h0055, 17'h0_0000);
    cmp("reload kept", 16'h003c, {8'h00, timer_reload});
    acc(1'b0, 1'b0, 16'h8000, 16'h0000, 17'h1_0000);
    $display("test timer and unmapped done");
    acc(1'b1, 1'b0, DA, 16'h0080, 17'h0_0000);
    acc(1'b1, 1'b0, IA, 16'h003f, 17'h0_0000);
    cmp("oe_n", 16'h00c0, {8'h00, pin_oe_n});
    repeat (6) @(posedge clk);
    acc(1'b0, 1'b0, DA, 16'h0000, 17'h1_0040);
    acc(1'b0, 1'b0, IA, 16'h0000, 17'h1_00ff);
    $display("test port read done");
    for (int k = 0; k < 5; k++) begin
      c = 1'($urandom);
      acc(1'b1, 1'b0, DA, 16'h0080, 17'h0_0000);
      bop(3'(k), 3'h0, c, DA);
      x = (k == 0 || k == 2 || (k == 3 && c) || (k == 4 && !c)) ? 8'h41 : 8'h40;
      cmp("latch after bit op", {8'h00, x}, {8'h00, pin_out});
    end
    tc = 8'($urandom);
    timer_count = tc;
    b = 3'($urandom);
    bop(3'h0, b, 1'b0, TA);
    cmp("reload after bit op", {8'h00, tc | (8'h01 << b)}, {8'h00, timer_reload});
    bop(3'h1, 3'h0, 1'b0, IA);
    cmp("oe_n after bit op", 16'h0001, {8'h00, pin_oe_n});
    $display("test bit ops done");
    wrap_up();
  end
endmodule
bind pbb_bridge pbb_bridge_sva #(.ROM_END(ROM_END), .RAM_BYTES(RAM_BYTES)) chk (
  .clk(clk), .rst(rst), .req(req), .req_we(req_we), .req_word(req_word), .req_addr(req_addr),
  .req_wdata(req_wdata), .ack(ack), .rdata(rdata), .bit_req(bit_req), .bit_done(bit_done),
  .rom_sel(rom_sel), .ram_sel(ram_sel), .unmapped(unmapped), .timer_count(timer_count),
  .timer_reload(timer_reload), .timer_reload_wr(timer_reload_wr));

//--- verification/pbb_pin_model.sv
`timescale 1ns/10ps
module pbb_pin_model (
  // pad side
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe_n,
  input  wire logic [7:0] ext,
  output logic      [7:0] pin_in
);
  // driven pins show the latch, others the board
  assign pin_in = (pin_oe_n & ext) | (~pin_oe_n & pin_out);
endmodule
